//--- verilog/uarm_top.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none
// How it works
// - All registers are 32 bits; undefined bits read back as zero.
// - Version word holds family 31:28, release 11:4, sub-version 3:0, read-only.
// - Path word holds fixed engine nibbles at 31:28, 27:24, 15:12, 11:8.
// - Interrupt enable has four read-write bits 31:28, cleared at reset.
// - Interrupt output is high while an enabled condition is pending.
// - Status bits set by hardware stay set until software writes one.
// - Status bits 31..28: bus error, MAC, transmit overflow, receive underflow.
// - All four monitor words update together once per second.
// - Each monitor word carries a 2-bit sample count in bits 1:0.
// - Measured counts sit in bits 31:2 in units of four bytes.
// - Transmit utilization advances on cycles with both transmit readies low.
// - Receive utilization advances on cycles with both receive readies low.
// - Upstream count accumulates payload of transmitted memory writes.
// - Downstream count accumulates payload of received completions with data.
// - Monitor control bit 0 is a soft reset clearing counters; resets to 0.
module uarm_top #(
    parameter int unsigned SAMPLE_CYCLES = uarm_pkg::SAMPLE_CYCLES_DFLT,
    parameter logic [3:0]  FAMILY_CODE   = 4'h5,  // Arbitrary value.
    parameter logic [7:0]  RELEASE_CODE  = 8'h3c, // Arbitrary value.
    parameter logic [3:0]  SUBVER_CODE   = 4'h7   // Arbitrary value.
) (
    input  wire logic                sys_clk,
    input  wire logic                arst_n,
    input  wire logic [15:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [15:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire uarm_pkg::uarm_trn_t trn_tx,
    input  wire uarm_pkg::uarm_trn_t trn_rx,
    input  wire uarm_pkg::uarm_evt_t evt,
    output var  logic                user_irq
);
    import uarm_pkg::*;

    logic [15:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic [15:0] ar_addr_r;
    logic        wr_go_w;
    logic        wr_ok_w;
    logic [3:0]  stat_clr_w;
    logic [3:0]  irq_en_r;
    logic [3:0]  irq_stat_r;
    logic        mon_rst_r;
    logic [31:0] tick_cnt_r;
    logic        tick_w;
    logic [1:0]  sample_r;
    logic        tx_beat_w;
    logic        rx_beat_w;
    logic [10:0] inc_w [NCH];
    wire  [31:0] mon_word [NCH];
    logic [31:0] version_w;
    logic [31:0] path_w;
    logic [31:0] rd_data_w;
    logic        rd_ok_w;

    // Payload length in four-byte units; a zero field means the maximum.
    function automatic logic [10:0] tlp_len(input logic [31:0] hdr);
        tlp_len = (hdr[9:0] == 10'h000) ? TLP_LEN_MAX : {1'b0, hdr[9:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path.

    // Address and data are taken in either order; each ready drops once taken.
    assign wr_go_w = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // Writes to read-only words are accepted and ignored; holes answer SLVERR.
    always_comb begin
        unique case (aw_addr_r)
            OFS_VERSION, OFS_PATH, OFS_IRQ_ENABLE, OFS_IRQ_STATUS,
            OFS_TX_UTIL, OFS_RX_UTIL, OFS_UP_WRITE, OFS_DN_CPL,
            OFS_MON_CTRL: wr_ok_w = 1'b1;
            default:      wr_ok_w = 1'b0;
        endcase
    end

    // Handshake and response state for the single outstanding write.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr_r     <= 16'h0000;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_r     <= {s_axi_awaddr[15:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
            end
            if (wr_go_w) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable, status and output.

    // Enable bits live in byte lane 3, so only that strobe changes them.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_en_r <= IRQ_ENABLE_RST;
        end else if (wr_go_w && aw_addr_r == OFS_IRQ_ENABLE && w_strb_r[3]) begin
            irq_en_r <= w_data_r[IRQ_LSB +: 4];
        end
    end

    assign stat_clr_w = (wr_go_w && aw_addr_r == OFS_IRQ_STATUS && w_strb_r[3])
                      ? w_data_r[IRQ_LSB +: 4] : 4'h0;

    // A new event in the clearing cycle wins, so no error is ever lost.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r <= IRQ_STATUS_RST;
        end else begin
            irq_stat_r <= (irq_stat_r & ~stat_clr_w) | evt;
        end
    end

    // Registered, so the output lags the pending condition by one cycle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            user_irq <= 1'b0;
        end else begin
            user_irq <= |(irq_stat_r & irq_en_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitor control and one-second sampling.

    // Software writes the soft reset and must write zero again to release it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_rst_r <= 1'b0;
        end else if (wr_go_w && aw_addr_r == OFS_MON_CTRL && w_strb_r[0]) begin
            mon_rst_r <= w_data_r[MON_RST_BIT];
        end
    end

    assign tick_w = (tick_cnt_r == SAMPLE_CYCLES - 32'd1) && !mon_rst_r;

    // The interval restarts with the soft reset, so the first sample is whole.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_r <= 32'h0000_0000;
            sample_r   <= 2'h0;
        end else if (mon_rst_r) begin
            tick_cnt_r <= 32'h0000_0000;
            sample_r   <= 2'h0;
        end else if (tick_w) begin
            tick_cnt_r <= 32'h0000_0000;
            sample_r   <= sample_r + 2'h1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'd1;
        end
    end

    // Per-cycle increments for each channel.
    assign tx_beat_w = !trn_tx.src_rdy_n && !trn_tx.dst_rdy_n;
    assign rx_beat_w = !trn_rx.src_rdy_n && !trn_rx.dst_rdy_n;

    // Each beat moves one 32-bit word, so utilization counts four-byte units.
    always_comb begin
        inc_w[CH_TXU] = {10'h000, tx_beat_w};
        inc_w[CH_RXU] = {10'h000, rx_beat_w};
        inc_w[CH_MWR] = 11'h000;
        inc_w[CH_CPL] = 11'h000;
        if (tx_beat_w && !trn_tx.sof_n && trn_tx.data[TLP_DATA_BIT]
            && trn_tx.data[28:24] == TLP_TYPE_MEM) begin
            inc_w[CH_MWR] = tlp_len(trn_tx.data);
        end
        if (rx_beat_w && !trn_rx.sof_n && trn_rx.data[TLP_DATA_BIT]
            && trn_rx.data[28:24] == TLP_TYPE_CPL) begin
            inc_w[CH_CPL] = tlp_len(trn_rx.data);
        end
    end

    // Live accumulator and published snapshot per channel; counts wrap.
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [29:0] acc_r;
        logic [29:0] snap_r;

        // The tick cycle's own increment opens the next interval.
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                acc_r  <= 30'h0000_0000;
                snap_r <= 30'h0000_0000;
            end else if (mon_rst_r) begin
                acc_r  <= 30'h0000_0000;
                snap_r <= 30'h0000_0000;
            end else if (tick_w) begin
                acc_r  <= {19'h0_0000, inc_w[i]};
                snap_r <= acc_r;
            end else begin
                acc_r  <= acc_r + {19'h0_0000, inc_w[i]};
            end
        end

        assign mon_word[i] = {snap_r, sample_r};
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path.

    assign version_w = {FAMILY_CODE, 16'h0000, RELEASE_CODE, SUBVER_CODE};
    assign path_w    = {HOST_TO_CARD_ENGINE0_CODE, HOST_TO_CARD_ENGINE1_CODE, 8'h00,
                        CARD_TO_HOST_ENGINE0_CODE, CARD_TO_HOST_ENGINE1_CODE, 8'h00};

    // Unused bit positions are padded with zero in every word.
    always_comb begin
        rd_ok_w = 1'b1;
        unique case ({s_axi_araddr[15:2], 2'b00})
            OFS_VERSION:    rd_data_w = version_w;
            OFS_PATH:       rd_data_w = path_w;
            OFS_IRQ_ENABLE: rd_data_w = {irq_en_r, 28'h000_0000};
            OFS_IRQ_STATUS: rd_data_w = {irq_stat_r, 28'h000_0000};
            OFS_TX_UTIL:    rd_data_w = mon_word[CH_TXU];
            OFS_RX_UTIL:    rd_data_w = mon_word[CH_RXU];
            OFS_UP_WRITE:   rd_data_w = mon_word[CH_MWR];
            OFS_DN_CPL:     rd_data_w = mon_word[CH_CPL];
            OFS_MON_CTRL:   rd_data_w = {31'h0000_0000, mon_rst_r};
            default: begin
                rd_data_w = 32'h0000_0000;
                rd_ok_w   = 1'b0;
            end
        endcase
    end

    // Data is captured at acceptance, so it is stable while rvalid waits.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
            ar_addr_r     <= 16'h0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data_w;
            s_axi_rresp   <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
            ar_addr_r     <= {s_axi_araddr[15:2], 2'b00};
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions and cover points.

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_version_read: assert property (
        s_axi_rvalid && ar_addr_r == OFS_VERSION |-> s_axi_rdata == version_w)
        else $error("Version word read back wrong.");

    a_path_read: assert property (
        s_axi_rvalid && ar_addr_r == OFS_PATH |-> s_axi_rdata[23:16] == 8'h00
        && s_axi_rdata[31:24] == {HOST_TO_CARD_ENGINE0_CODE, HOST_TO_CARD_ENGINE1_CODE})
        else $error("Path word read back wrong.");

    a_irq_follows: assert property (
        (|(irq_stat_r & irq_en_r)) |=> user_irq)
        else $error("Enabled pending event did not raise the interrupt.");

    a_irq_quiet: assert property (
        !(|(irq_stat_r & irq_en_r)) |=> !user_irq)
        else $error("Interrupt high with nothing enabled pending.");

    a_stat_sticky: assert property (
        (irq_stat_r & ~stat_clr_w) != 4'h0 |=>
        (~irq_stat_r & $past(irq_stat_r) & ~$past(stat_clr_w)) == 4'h0)
        else $error("Status bit dropped without a clearing write.");

    a_evt_sets: assert property (
        evt != 4'h0 |=> (irq_stat_r & $past(evt)) == $past(evt))
        else $error("Event did not set its status bit.");

    a_sample_step: assert property (
        tick_w |=> sample_r == $past(sample_r) + 2'h1)
        else $error("Sample count did not step on the interval tick.");

    a_snap_hold: assert property (
        !tick_w && !mon_rst_r |=> $stable(g_ch[CH_RXU].snap_r) && $stable(sample_r))
        else $error("Monitor word changed between ticks.");

    a_tx_util: assert property (
        !trn_tx.src_rdy_n && !trn_tx.dst_rdy_n && !tick_w && !mon_rst_r
        |=> g_ch[CH_TXU].acc_r == $past(g_ch[CH_TXU].acc_r) + 30'h1)
        else $error("Transmit utilization missed a beat.");

    a_rx_idle: assert property (
        trn_rx.src_rdy_n && !tick_w && !mon_rst_r |=> $stable(g_ch[CH_RXU].acc_r))
        else $error("Receive utilization moved without a beat.");

    a_mwr_bytes: assert property (
        tx_beat_w && !trn_tx.sof_n && trn_tx.data[30] && trn_tx.data[28:24] == 5'h00
        && !tick_w && !mon_rst_r |=> g_ch[CH_MWR].acc_r ==
        $past(g_ch[CH_MWR].acc_r) + {19'h0_0000, tlp_len($past(trn_tx.data))})
        else $error("Memory write payload not added.");

    a_soft_hold: assert property (
        mon_rst_r [*2] |-> sample_r == 2'h0 && tick_cnt_r == 32'h0000_0000
        && g_ch[CH_CPL].acc_r == 30'h0000_0000 && g_ch[CH_TXU].snap_r == 30'h0000_0000)
        else $error("Monitor not held at zero under soft reset.");

    c_stat_clear: cover property (irq_stat_r[3] ##1 !irq_stat_r[3]);
    c_irq_rise: cover property (!user_irq ##1 user_irq);
    c_tick: cover property (tick_w ##[1:8] s_axi_rvalid);
    c_cpl_seen: cover property (inc_w[CH_CPL] != 11'h000);
endmodule
`default_nettype wire

//--- verilog/uarm_pkg.sv
`default_nettype none
package uarm_pkg;
    // Register byte addresses, one aligned 32-bit word each.
    localparam int unsigned ADDR_W          = 16;
    localparam logic [15:0] OFS_VERSION     = 16'h8000;
    localparam logic [15:0] OFS_PATH        = 16'h8004;
    localparam logic [15:0] OFS_IRQ_ENABLE  = 16'h8100;
    localparam logic [15:0] OFS_IRQ_STATUS  = 16'h8104;
    localparam logic [15:0] OFS_TX_UTIL     = 16'h8200;
    localparam logic [15:0] OFS_RX_UTIL     = 16'h8204;
    localparam logic [15:0] OFS_UP_WRITE    = 16'h8208;
    localparam logic [15:0] OFS_DN_CPL      = 16'h820c;
    localparam logic [15:0] OFS_MON_CTRL    = 16'h8210;
    // Field positions.
    localparam int unsigned FAMILY_LSB      = 28;
    localparam int unsigned RELEASE_LSB     = 4;
    localparam int unsigned SUBVER_LSB      = 0;
    localparam int unsigned IRQ_LSB         = 28;
    localparam int unsigned MON_RST_BIT     = 0;
    // Fixed path codes per engine nibble.
    localparam logic [3:0]  HOST_TO_CARD_ENGINE0_CODE = 4'h1;
    localparam logic [3:0]  HOST_TO_CARD_ENGINE1_CODE = 4'h2;
    localparam logic [3:0]  CARD_TO_HOST_ENGINE0_CODE = 4'h9;
    localparam logic [3:0]  CARD_TO_HOST_ENGINE1_CODE = 4'ha;
    // Reset values.
    localparam logic [3:0]  IRQ_ENABLE_RST  = 4'h0;
    localparam logic [3:0]  IRQ_STATUS_RST  = 4'h0;
    // AXI responses.
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Packet header fields on the first beat.
    localparam int unsigned TLP_DATA_BIT    = 30;
    localparam logic [4:0]  TLP_TYPE_MEM    = 5'h00;
    localparam logic [4:0]  TLP_TYPE_CPL    = 5'h0a;
    localparam logic [10:0] TLP_LEN_MAX     = 11'h400;
    // Monitor channels.
    localparam int unsigned NCH             = 4;
    localparam int unsigned CH_TXU          = 0;
    localparam int unsigned CH_RXU          = 1;
    localparam int unsigned CH_MWR          = 2;
    localparam int unsigned CH_CPL          = 3;
    // Sample interval timing.
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000_000;
    localparam int unsigned SAMPLE_CYCLES_DFLT = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // One beat of a transaction interface, ready strobes active low.
    typedef struct packed {
        logic        sof_n;
        logic        src_rdy_n;
        logic        dst_rdy_n;
        logic [31:0] data;
    } uarm_trn_t;

    // Interrupt sources, ordered as status bits 31 down to 28.
    typedef struct packed {
        logic local_bus_error_flag;
        logic mac_interrupt_flag;
        logic memctl_tx_overflow_flag;
        logic memctl_rx_underflow_flag;
    } uarm_evt_t;
endpackage
`default_nettype wire

//--- dv/uarm_trn_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side of both transaction interfaces, fed by random words from the bench.
module uarm_trn_model (
    input  wire logic                sys_clk,
    input  wire logic                arst_n,
    input  wire logic                run,
    input  wire logic [31:0]         rnd,
    output var  uarm_pkg::uarm_trn_t trn_tx,
    output var  uarm_pkg::uarm_trn_t trn_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    import uarm_pkg::*;

    // Data changes every cycle, so a stale word never passes for a header.
    function automatic uarm_trn_t mk(input logic [31:0] r, input logic go, input logic [4:0] ty);
        uarm_trn_t t;
        t.sof_n     = r[0];
        t.src_rdy_n = ~go | r[1];
        t.dst_rdy_n = r[2] & r[3];
        t.data      = r;
        if (r[4]) begin
            t.data[28:24] = ty;
            t.data[9:0] = r[5] ? 10'h000 : r[9:0];
        end
        return t;
    endfunction

    // Both directions step every cycle; no beats while stopped or in reset.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            trn_tx <= '{sof_n: 1'b1, src_rdy_n: 1'b1, dst_rdy_n: 1'b1, data: 32'h0000_0000};
            trn_rx <= '{sof_n: 1'b1, src_rdy_n: 1'b1, dst_rdy_n: 1'b1, data: 32'hffff_ffff};
        end else begin
            trn_tx <= mk(rnd, run, TLP_TYPE_MEM);
            trn_rx <= mk({rnd[15:0], rnd[31:16]}, run, TLP_TYPE_CPL);
        end
    end
endmodule
`default_nettype wire

//--- dv/uarm_top_tb.sv
`default_nettype none
module uarm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uarm_pkg::*;
    localparam int unsigned SC  = 20;
    localparam logic [3:0]  FAM = 4'h5;  // Arbitrary value.
    localparam logic [7:0]  REL = 8'h3c; // Arbitrary value.
    localparam logic [3:0]  SUB = 4'h7;  // Arbitrary value.
    logic        sys_clk, arst_n, user_irq, run, m_ctl, pend;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, pr, pd, r;
    logic [31:0] rng = 32'h0000_d54f;
    logic [3:0]  s_axi_wstrb, m_en, m_st, ps;
    logic [1:0]  s_axi_bresp, s_axi_rresp, m_smp;
    logic [15:0] pa;
    logic [15:0] tbl [10];
    logic [29:0] m_snap [4];
    logic [29:0] m_acc [4];
    uarm_trn_t   trn_tx, trn_rx;
    uarm_evt_t   evt;
    int          m_cnt, err_total, tests_run;

    uarm_top #(.SAMPLE_CYCLES(SC), .FAMILY_CODE(FAM), .RELEASE_CODE(REL), .SUBVER_CODE(SUB)) i_uarm_top (
        .sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .trn_tx, .trn_rx, .evt, .user_irq);
    uarm_trn_model i_uarm_trn_model (.sys_clk, .arst_n, .run, .rnd(pr), .trn_tx, .trn_rx);

    ////////////////////////////////////////////////////////////////////////////////
    // Shared generator; the main sequence and the traffic feed both draw from it.
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [29:0] bt(input uarm_trn_t t);
        return {29'h0, !t.src_rdy_n && !t.dst_rdy_n};
    endfunction

    // Payload in dwords of a header beat of the given type, zero length meaning the maximum.
    function automatic logic [29:0] pay(input uarm_trn_t t, input logic [4:0] ty);
        if (bt(t) == 30'h1 && !t.sof_n && t.data[TLP_DATA_BIT] && t.data[28:24] == ty) begin
            return (t.data[9:0] == 10'h000) ? 30'h400 : {20'h0_0000, t.data[9:0]};
        end
        return 30'h0;
    endfunction

    // Expected response and data of a read, from the reference state before this edge.
    function automatic logic [33:0] exp_rd(input logic [15:0] a);
        case (a & 16'hfffc)
            OFS_VERSION:    return {RESP_OKAY, FAM, 16'h0000, REL, SUB};
            OFS_PATH:       return {RESP_OKAY, HOST_TO_CARD_ENGINE0_CODE, 4'h2, 8'h00, 4'h9, 4'ha, 8'h00};
            OFS_IRQ_ENABLE: return {RESP_OKAY, m_en, 28'h000_0000};
            OFS_IRQ_STATUS: return {RESP_OKAY, m_st, 28'h000_0000};
            OFS_TX_UTIL:    return {RESP_OKAY, m_snap[0], m_smp};
            OFS_RX_UTIL:    return {RESP_OKAY, m_snap[1], m_smp};
            OFS_UP_WRITE:   return {RESP_OKAY, m_snap[2], m_smp};
            OFS_DN_CPL:     return {RESP_OKAY, m_snap[3], m_smp};
            OFS_MON_CTRL:   return {RESP_OKAY, 31'h0000_0000, m_ctl};
            default:        return {RESP_SLVERR, 32'h0000_0000};
        endcase
    endfunction

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        tests_run++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One read; request held until taken, rready held until rvalid is seen.
    task automatic rd(input logic [15:0] a);
        logic [33:0] e;
        int          n;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                e = exp_rd(a);
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) begin
            $display("[FAIL] read %h expected response seen timeout", a);
            err_total++;
            finish_test();
        end else begin
            chk($sformatf("read %h", a), e, {s_axi_rresp, s_axi_rdata});
        end
    endtask

    // One write; the reference applies it at the edge where bvalid is first seen.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        {pa, pd, ps, pend} = {a, d, st, 1'b1};
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, st};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) begin
            $display("[FAIL] write %h expected response seen timeout", a);
            err_total++;
            finish_test();
        end else begin
            chk($sformatf("bresp %h", a), {32'h0, er}, {32'h0, s_axi_bresp});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reference registers and monitor, updated with non-blocking writes so reads see the old state.
    always @(posedge sys_clk or negedge arst_n) begin : ref_model
        logic        c;
        logic [29:0] inc [4];
        if (!arst_n) begin
            {m_cnt, m_smp, m_en, m_st, m_ctl} <= '0;
            m_snap <= '{default: 30'h0};
            m_acc  <= '{default: 30'h0};
        end else begin
            c = m_ctl;
            inc = '{bt(trn_tx), bt(trn_rx), pay(trn_tx, TLP_TYPE_MEM), pay(trn_rx, TLP_TYPE_CPL)};
            m_st <= m_st | evt;
            if (s_axi_bvalid && pend) begin
                pend <= 1'b0;
                if (pa == OFS_IRQ_ENABLE && ps[3]) m_en <= pd[31:28];
                if (pa == OFS_IRQ_STATUS && ps[3]) m_st <= (m_st & ~pd[31:28]) | evt;
                if (pa == OFS_MON_CTRL && ps[0]) c = pd[0];
            end
            m_ctl <= c;
            for (int i = 0; i < 4; i++) begin
                if (c) begin
                    {m_snap[i], m_acc[i]} <= 60'h0;
                end else if (m_cnt == SC - 1) begin
                    m_snap[i] <= m_acc[i];
                    m_acc[i]  <= inc[i];
                end else begin
                    m_acc[i]  <= m_acc[i] + inc[i];
                end
            end
            m_cnt <= (c || m_cnt == SC - 1) ? 0 : m_cnt + 1;
            m_smp <= c ? 2'h0 : m_smp + ((m_cnt == SC - 1) ? 2'h1 : 2'h0);
        end
    end

    // Clock at 40 MHz and a fresh random word for the traffic model every cycle.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) pr <= rnd();

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, run, pend} = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {evt, err_total, tests_run} = '0;
        tbl = '{OFS_VERSION, OFS_PATH, OFS_IRQ_ENABLE, OFS_IRQ_STATUS, OFS_TX_UTIL, OFS_RX_UTIL,
                OFS_UP_WRITE, OFS_DN_CPL, OFS_MON_CTRL, 16'h8108};
        arst_n = 1'b1;
        #1 arst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rd(tbl[i]);
        chk("user_irq", 34'h0, {33'h0, user_irq});
        $display("reset values done");
        // Lane 3 off leaves the enables alone; read-only and unmapped places ignore writes.
        wr(OFS_IRQ_ENABLE, 32'hffff_ffff, 4'h7, RESP_OKAY);
        rd(OFS_IRQ_ENABLE);
        wr(OFS_IRQ_ENABLE, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd(OFS_IRQ_ENABLE);
        wr(OFS_VERSION, 32'h0000_0000, 4'hf, RESP_OKAY);
        wr(OFS_PATH, 32'h0000_0000, 4'hf, RESP_OKAY);
        wr(16'h8300, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        for (int i = 0; i < 2; i++) rd(tbl[i]);
        rd(16'h8300);
        $display("access kinds done");
        repeat (6) begin
            r = rnd();
            wr(OFS_IRQ_ENABLE, r, 4'hf, RESP_OKAY);
            @(posedge sys_clk);
            r = rnd();
            evt <= uarm_evt_t'(r[3:0]);
            @(posedge sys_clk);
            evt <= uarm_evt_t'(r[7:4]);
            @(posedge sys_clk);
            evt <= '0;
            repeat (2) @(posedge sys_clk);
            chk("user_irq", {33'h0, |(m_st & m_en)}, {33'h0, user_irq});
            rd(OFS_IRQ_STATUS);
            wr(OFS_IRQ_STATUS, rnd(), 4'hf, RESP_OKAY);
            rd(OFS_IRQ_STATUS);
            chk("user_irq", {33'h0, |(m_st & m_en)}, {33'h0, user_irq});
        end
        $display("interrupts done");
        run <= 1'b1;
        repeat (40) begin
            r = rnd();
            repeat (r[4:0]) @(posedge sys_clk);
            rd(OFS_TX_UTIL + {12'h000, r[6:5], 2'h0});
        end
        $display("monitor done");
        wr(OFS_MON_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
        repeat (2 * SC) @(posedge sys_clk);
        for (int i = 4; i < 9; i++) rd(tbl[i]);
        wr(OFS_MON_CTRL, 32'h0000_0000, 4'h1, RESP_OKAY);
        repeat (12) begin
            r = rnd();
            repeat (r[4:0]) @(posedge sys_clk);
            rd(OFS_TX_UTIL + {12'h000, r[6:5], 2'h0});
        end
        $display("soft reset done");
        finish_test();
    end
endmodule
`default_nettype wire
